//--- hw/isx_core.sv
// Purpose: executes inc-skip, or-reg, or-imm and aux-page read
// Assumes: one instruction presented per cycle with instr_valid_i
// Notes:   file and aux registers held here as flip-flops
//
// Contract
// - increment file register 0..63; d=0 to accumulator, d=1 to register
// - zero result drops next fetched instruction, runs nop, two cycles
// - or accumulator with register to chosen dest, zero flag, one cycle
// - or accumulator with 8-bit immediate into accumulator, zero flag
// - copy aux register 0..15 to accumulator, flags untouched, one cycle
`timescale 1ns/1ps
module isx_core
   import isx_pkg::*;
#(
   parameter int unsigned NFILE = FILE_DEPTH,
   parameter int unsigned NAUX  = AUX_DEPTH
)(
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               instr_valid_i,
   input  wire logic [2:0]         op_i,
   input  wire logic               dest_i,
   input  wire logic [FADDR_W-1:0] faddr_i,
   input  wire logic [AADDR_W-1:0] aaddr_i,
   input  wire logic [DATA_W-1:0]  imm_i,
   input  wire logic               aux_we_i,
   input  wire logic [AADDR_W-1:0] aux_waddr_i,
   input  wire logic [DATA_W-1:0]  aux_wdata_i,
   output logic      [DATA_W-1:0]  acc_o,
   output logic                    zero_o,
   output logic                    skip_o,
   output logic                    retired_o
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] file_q [NFILE];
   logic [DATA_W-1:0] aux_q  [NAUX];
   logic [DATA_W-1:0] acc_q, acc_d;
   logic              zf_q, zf_d;
   logic              skip_q, skip_d;
   logic              ret_q, ret_d;
   logic [DATA_W-1:0] res;
   logic              res_zero;
   logic              exec;
   logic              file_wr;

   // a pending skip turns the next slot into a nop
   assign exec = instr_valid_i && !skip_q;

   isx_alu u_alu (
      .op_i   (op_i),
      .acc_i  (acc_q),
      .freg_i (file_q[faddr_i]),
      .imm_i  (imm_i),
      .aux_i  (aux_q[aaddr_i]),
      .res_o  (res),
      .zero_o (res_zero)
   );

   // ----------------------------------------------------------------
   // write enables
   // ----------------------------------------------------------------
   // or-imm never writes the file, whatever dest_i says
   assign file_wr = exec && dest_i == DEST_REG
                    && (op_i == OP_INC_SKZ || op_i == OP_OR_REG);

   // ----------------------------------------------------------------
   // accumulator and zero flag
   // ----------------------------------------------------------------
   always_comb begin
      acc_d = acc_q;
      zf_d  = zf_q;
      if (exec) begin
         unique case (op_i)
            OP_INC_SKZ: begin
               // flags left alone: only the skip reacts to zero
               if (dest_i == DEST_ACC) acc_d = res;
            end
            OP_OR_REG: begin
               if (dest_i == DEST_ACC) acc_d = res;
               zf_d = res_zero;
            end
            OP_OR_IMM: begin
               acc_d = res;
               zf_d  = res_zero;
            end
            OP_AUX_RD: acc_d = res;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         acc_q <= ZERO_BYTE;
         zf_q  <= 1'b0;
      end else begin
         acc_q <= acc_d;
         zf_q  <= zf_d;
      end
   end

   // ----------------------------------------------------------------
   // skip and retire
   // ----------------------------------------------------------------
   // a dropped slot clears the skip; idle cycles keep it pending
   always_comb begin
      skip_d = skip_q;
      ret_d  = exec;
      if (instr_valid_i) skip_d = 1'b0;
      if (exec && op_i == OP_INC_SKZ) skip_d = res_zero;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         skip_q <= 1'b0;
         ret_q  <= 1'b0;
      end else begin
         skip_q <= skip_d;
         ret_q  <= ret_d;
      end
   end

   // ----------------------------------------------------------------
   // file registers, one byte of flip-flops per entry
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NFILE; g++) begin : g_file
      logic [DATA_W-1:0] ent_d;
      logic [DATA_W-1:0] ent_q;

      always_comb begin
         ent_d = ent_q;
         if (file_wr && faddr_i == FADDR_W'(g)) begin
            ent_d = res;
         end
      end

      always_ff @(posedge clk_i or posedge rst_i) begin
         if (rst_i) begin
            ent_q <= ZERO_BYTE;
         end else begin
            ent_q <= ent_d;
         end
      end

      assign file_q[g] = ent_q;
   end

   // ----------------------------------------------------------------
   // aux page, loaded only from the side port
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NAUX; g++) begin : g_aux
      logic [DATA_W-1:0] ent_d;
      logic [DATA_W-1:0] ent_q;

      // reads never disturb an entry, so a read is free of side effects
      always_comb begin
         ent_d = ent_q;
         if (aux_we_i && aux_waddr_i == AADDR_W'(g)) begin
            ent_d = aux_wdata_i;
         end
      end

      always_ff @(posedge clk_i or posedge rst_i) begin
         if (rst_i) begin
            ent_q <= ZERO_BYTE;
         end else begin
            ent_q <= ent_d;
         end
      end

      assign aux_q[g] = ent_q;
   end

   assign acc_o     = acc_q;
   assign zero_o    = zf_q;
   assign skip_o    = skip_q;
   assign retired_o = ret_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence inc_zero_s;
      exec && op_i == OP_INC_SKZ && res_zero;
   endsequence

   // a valid slot offered while a skip is pending
   sequence drop_slot_s;
      skip_q && instr_valid_i;
   endsequence

   inc_dest_reg_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      exec && op_i == OP_INC_SKZ && dest_i == DEST_REG
      |=> file_q[$past(faddr_i)] == $past(file_q[faddr_i]) + ONE_BYTE)
      else $error("increment not stored to register");

   inc_dest_acc_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      exec && op_i == OP_INC_SKZ && dest_i == DEST_ACC
      |=> acc_q == $past(file_q[faddr_i]) + ONE_BYTE
          && file_q[$past(faddr_i)] == $past(file_q[faddr_i]))
      else $error("increment not stored to accumulator");

   skip_next_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      inc_zero_s ##1 drop_slot_s |=> !ret_q && !skip_q)
      else $error("skipped slot executed");

   no_skip_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      exec && op_i == OP_INC_SKZ && !res_zero |=> !skip_q)
      else $error("skip without zero result");

   skip_hold_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      skip_q && !instr_valid_i |=> skip_q)
      else $error("pending skip lost while idle");

   drop_keep_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      drop_slot_s |=> $stable(acc_q) && $stable(zf_q))
      else $error("dropped slot changed state");

   or_reg_zf_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      exec && op_i == OP_OR_REG && dest_i == DEST_ACC
      |=> acc_q == ($past(acc_q) | $past(file_q[faddr_i]))
          && zf_q == (acc_q == ZERO_BYTE))
      else $error("or with register wrong");

   or_reg_dst_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      exec && op_i == OP_OR_REG && dest_i == DEST_REG
      |=> file_q[$past(faddr_i)] == ($past(acc_q) | $past(file_q[faddr_i]))
          && $stable(acc_q)
          && zf_q == (file_q[$past(faddr_i)] == ZERO_BYTE))
      else $error("or into register wrong");

   or_imm_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      exec && op_i == OP_OR_IMM
      |=> acc_q == ($past(acc_q) | $past(imm_i)))
      else $error("or with immediate wrong");

   one_cycle_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      exec |=> ret_q)
      else $error("instruction not retired in one cycle");

   aux_read_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      exec && op_i == OP_AUX_RD
      |=> acc_q == $past(aux_q[aaddr_i]) && $stable(zf_q))
      else $error("aux read wrong or flag touched");

   aux_src_keep_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      exec && op_i == OP_AUX_RD && !aux_we_i
      |=> aux_q[$past(aaddr_i)] == $past(aux_q[aaddr_i]))
      else $error("aux read disturbed its source");

   zero_flag_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      exec && op_i == OP_OR_IMM |=> zf_q == (acc_q == ZERO_BYTE))
      else $error("zero flag mismatch");
endmodule

//--- hw/isx_pkg.sv
// Purpose: shared constants for the four-instruction execution core
// Assumes: 8-bit data, 64 file registers, 16 auxiliary registers
// Notes:   opcode codes are local to this core
package isx_pkg;
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned FILE_DEPTH = 64;
   localparam int unsigned AUX_DEPTH  = 16;
   localparam int unsigned FADDR_W    = 6;
   localparam int unsigned AADDR_W    = 4;
   localparam logic [7:0]  ZERO_BYTE  = 8'h00;
   localparam logic [7:0]  ONE_BYTE   = 8'h01;
   localparam logic        DEST_ACC   = 1'b0;
   localparam logic        DEST_REG   = 1'b1;

   typedef enum logic [2:0] {
      OP_NOP     = 3'b000,
      OP_INC_SKZ = 3'b001,
      OP_OR_REG  = 3'b010,
      OP_OR_IMM  = 3'b011,
      OP_AUX_RD  = 3'b100
   } isx_op_t;
endpackage

//--- hw/isx_alu.sv
// Purpose: combinational result path of the core
// Assumes: operands already fetched
// Notes:   zero flag computed on every result
`timescale 1ns/1ps
module isx_alu
   import isx_pkg::*;
(
   input  wire logic [2:0]        op_i,
   input  wire logic [DATA_W-1:0] acc_i,
   input  wire logic [DATA_W-1:0] freg_i,
   input  wire logic [DATA_W-1:0] imm_i,
   input  wire logic [DATA_W-1:0] aux_i,
   output logic      [DATA_W-1:0] res_o,
   output logic                   zero_o
);
   always_comb begin
      unique case (op_i)
         OP_INC_SKZ: res_o = freg_i + ONE_BYTE;
         OP_OR_REG:  res_o = acc_i | freg_i;
         OP_OR_IMM:  res_o = acc_i | imm_i;
         OP_AUX_RD:  res_o = aux_i;
         default:    res_o = acc_i;
      endcase
   end
   assign zero_o = (res_o == ZERO_BYTE);
endmodule

//--- bench/inc_skip_or_sfr_read_exec_tb.sv
// Purpose: self-checking bench for the four-instruction core
// Assumes: inputs move on the falling edge, results read one cycle on
// Notes:   accumulator is loaded through aux reads, file regs via or
`timescale 1ns/1ps
module inc_skip_or_sfr_read_exec_tb
   import isx_pkg::*;
;
   typedef struct packed {
      logic       v;
      logic [2:0] op;
      logic       d;
      logic [5:0] fa;
      logic [3:0] aa;
      logic [7:0] imm;
      logic [7:0] acc;
      logic       z;
      logic       sk;
      logic       rt;
   } isx_row_t;

   logic       clk_i, rst_i, instr_valid_i, dest_i, aux_we_i;
   logic [2:0] op_i;
   logic [5:0] faddr_i;
   logic [3:0] aaddr_i, aux_waddr_i;
   logic [7:0] imm_i, aux_wdata_i, acc_o;
   logic       zero_o, skip_o, retired_o;
   int         n_errors, cmp_count;
   isx_row_t   rows [21];

   isx_core uut (.clk_i(clk_i), .rst_i(rst_i),
      .instr_valid_i(instr_valid_i), .op_i(op_i), .dest_i(dest_i),
      .faddr_i(faddr_i), .aaddr_i(aaddr_i), .imm_i(imm_i),
      .aux_we_i(aux_we_i), .aux_waddr_i(aux_waddr_i),
      .aux_wdata_i(aux_wdata_i), .acc_o(acc_o), .zero_o(zero_o),
      .skip_o(skip_o), .retired_o(retired_o));

   initial begin
      clk_i = 1'h0;
      forever #4 clk_i = ~clk_i;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      if (n_errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ----------------------------------------
   // watchdog, run needs well under 100 cycles
   // ----------------------------------------
   initial begin
      #(400*8);
      n_errors++;
      final_report();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rows = '{
         '{1'h1,OP_AUX_RD ,1'h0,6'h00,4'hf,8'h00,8'haa,1'h0,1'h0,1'h1},
         '{1'h1,OP_OR_IMM ,1'h0,6'h00,4'h0,8'h50,8'hfa,1'h0,1'h0,1'h1},
         '{1'h1,OP_OR_REG ,1'h1,6'h05,4'h0,8'h00,8'hfa,1'h0,1'h0,1'h1},
         '{1'h1,OP_AUX_RD ,1'h0,6'h00,4'h0,8'h00,8'h00,1'h0,1'h0,1'h1},
         '{1'h1,OP_OR_IMM ,1'h0,6'h00,4'h0,8'h00,8'h00,1'h1,1'h0,1'h1},
         '{1'h1,OP_AUX_RD ,1'h0,6'h00,4'h3,8'h00,8'h55,1'h1,1'h0,1'h1},
         '{1'h1,OP_OR_REG ,1'h0,6'h05,4'h0,8'h00,8'hff,1'h0,1'h0,1'h1},
         '{1'h1,OP_OR_REG ,1'h1,6'h05,4'h0,8'h00,8'hff,1'h0,1'h0,1'h1},
         '{1'h1,OP_INC_SKZ,1'h1,6'h05,4'h0,8'h00,8'hff,1'h0,1'h1,1'h1},
         '{1'h1,OP_OR_IMM ,1'h0,6'h00,4'h0,8'h0f,8'hff,1'h0,1'h0,1'h0},
         '{1'h1,OP_AUX_RD ,1'h0,6'h00,4'h0,8'h00,8'h00,1'h0,1'h0,1'h1},
         '{1'h1,OP_OR_REG ,1'h0,6'h05,4'h0,8'h00,8'h00,1'h1,1'h0,1'h1},
         '{1'h1,OP_INC_SKZ,1'h0,6'h3f,4'h0,8'h00,8'h01,1'h1,1'h0,1'h1},
         '{1'h1,OP_OR_IMM ,1'h0,6'h00,4'h0,8'h00,8'h01,1'h0,1'h0,1'h1},
         '{1'h1,OP_OR_IMM ,1'h0,6'h00,4'h0,8'hff,8'hff,1'h0,1'h0,1'h1},
         '{1'h1,OP_OR_REG ,1'h1,6'h3f,4'h0,8'h00,8'hff,1'h0,1'h0,1'h1},
         '{1'h1,OP_INC_SKZ,1'h0,6'h3f,4'h0,8'h00,8'h00,1'h0,1'h1,1'h1},
         '{1'h0,OP_OR_IMM ,1'h0,6'h00,4'h0,8'h0f,8'h00,1'h0,1'h1,1'h0},
         '{1'h0,OP_NOP    ,1'h0,6'h00,4'h0,8'h00,8'h00,1'h0,1'h1,1'h0},
         '{1'h1,OP_OR_IMM ,1'h0,6'h00,4'h0,8'h0f,8'h00,1'h0,1'h0,1'h0},
         '{1'h1,OP_OR_REG ,1'h0,6'h3f,4'h0,8'h00,8'hff,1'h0,1'h0,1'h1}};
      n_errors = 0;
      cmp_count = 0;
      rst_i = 1'h1;
      {instr_valid_i, op_i, dest_i, faddr_i, aaddr_i, imm_i} = '0;
      {aux_we_i, aux_waddr_i, aux_wdata_i} = '0;
      repeat (6) @(negedge clk_i);
      rst_i = 1'h0;
      check(acc_o, 8'h00);
      check(8'({zero_o, skip_o, retired_o}), 8'h00);
      // preload aux registers through the side port
      {aux_we_i, aux_waddr_i, aux_wdata_i} = {1'h1, 4'h3, 8'h55};
      @(negedge clk_i);
      {aux_we_i, aux_waddr_i, aux_wdata_i} = {1'h1, 4'hf, 8'haa};
      @(negedge clk_i);
      aux_we_i = 1'h0;
      foreach (rows[i]) begin
         {instr_valid_i, op_i, dest_i, faddr_i, aaddr_i, imm_i} = rows[i][33:11];
         @(negedge clk_i);
         check(acc_o, rows[i].acc);
         check(8'(zero_o), 8'(rows[i].z));
         check(8'(skip_o), 8'(rows[i].sk));
         check(8'(retired_o), 8'(rows[i].rt));
      end
      // leave a skip pending so the reset has something to clear
      {instr_valid_i, op_i, dest_i, faddr_i} = {1'h1, OP_INC_SKZ, 1'h1, 6'h3f};
      @(negedge clk_i);
      check(8'(skip_o), 8'h01);
      // mid-run reset clears state, aux contents too
      rst_i = 1'h1;
      instr_valid_i = 1'h0;
      @(negedge clk_i);
      check(acc_o, 8'h00);
      check(8'({zero_o, skip_o, retired_o}), 8'h00);
      rst_i = 1'h0;
      {instr_valid_i, op_i, aaddr_i} = {1'h1, OP_AUX_RD, 4'h3};
      @(negedge clk_i);
      check(acc_o, 8'h00);
      check(8'(retired_o), 8'h01);
      final_report();
   end
endmodule
